// ===== src/lic_pkg.sv
// Purpose: Shared constants and types for the line control register bank
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes:   Printed offsets are not multiples of four, so they are indices
package lic_pkg;

  localparam logic [7:0] IDX_LINE_CTRL3   = 8'h12;
  localparam logic [7:0] IDX_OVL_STATUS   = 8'h13;
  localparam logic [7:0] IDX_CTRL2        = 8'h20;
  localparam logic [7:0] IDX_CTRL1        = 8'h21;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h22;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'h23;

  localparam int BIT_BOOST     = 6;
  localparam int BIT_FORCE_LV  = 5;
  localparam int BIT_TRIM_HI   = 4;
  localparam int BIT_TRIM_LO   = 3;
  localparam int BIT_FULL_WAVE = 1;
  localparam int BIT_SQUELCH   = 0;
  localparam int BIT_OVL_LIVE  = 2;
  localparam int BIT_OVL_UNDEF = 7;
  localparam int BIT_BTE       = 2;
  localparam int BIT_ROV       = 1;
  localparam int BIT_DCT_HI    = 3;
  localparam int BIT_DCT_LO    = 2;
  localparam int IRQ_W         = 2;

  localparam logic [7:0] CTRL3_WMASK  = 8'h7b;
  localparam logic [7:0] CTRL2_WMASK  = 8'h04;
  localparam logic [7:0] CTRL1_WMASK  = 8'h0c;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [1:0] DCT_STANDARD = 2'h2;
  localparam logic [1:0] DCT_CURLIM   = 2'h3;
  localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

  localparam logic [1:0] TRIM_NORMAL = 2'h0;
  localparam logic [1:0] TRIM_M125   = 2'h1;
  localparam logic [1:0] TRIM_P250   = 2'h2;
  localparam logic [1:0] TRIM_P125   = 2'h3;

  typedef enum logic [1:0] {
    LIC_VADJ_NONE,
    LIC_VADJ_MINUS_125MV,
    LIC_VADJ_PLUS_250MV,
    LIC_VADJ_PLUS_125MV
  } lic_vadj_t;

  typedef struct packed {
    logic      tone_headroom_boost;
    logic      low_volt_termination;
    logic      keep_minus1dbm_level;
    lic_vadj_t line_voltage_adjust;
    logic      ring_full_wave_select;
    logic      ring_network_squelch;
  } lic_line_ctrl_t;

endpackage : lic_pkg

// ===== src/lic_ovl_track.sv
// Purpose: Live and sticky receive overload tracking
// Assumes: overload_in already synchronised to hclk
// Notes:   Sticky flag set wins over a software clear in the same cycle
`timescale 1ns/1ps
module lic_ovl_track
  import lic_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic overload_in,
  input  wire logic billing_tone_detect_enable,
  input  wire logic sticky_clear,
  output logic      overload_live_flag,
  output logic      overload_sticky_flag,
  output logic      overload_rise
);

  logic qualified;

  assign qualified = overload_in & billing_tone_detect_enable;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      overload_live_flag <= 1'b0;
    else
      overload_live_flag <= qualified;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      overload_sticky_flag <= 1'b0;
    else if (qualified)
      overload_sticky_flag <= 1'b1;
    else if (sticky_clear)
      overload_sticky_flag <= 1'b0;
  end

  assign overload_rise = qualified & ~overload_live_flag;

endmodule : lic_ovl_track

// ===== src/lic_regs.sv
// Purpose: Line interface control and overload status registers on AHB-Lite
// Assumes: One clock; overload_pin and ring_pin are asynchronous pins
// Notes:   Zero wait states; every response OKAY
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module lic_regs
  import lic_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [2:0]  hburst,
  input  wire logic [3:0]  hprot,
  input  wire logic        hmastlock,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        overload_pin,
  input  wire logic        ring_pin,
  output logic             ring_detect_output,
  output logic             ring_data_bit,
  output lic_line_ctrl_t   line_ctrl,
  output logic             irq
);

  logic [7:0]       ctrl3;
  logic [7:0]       ctrl2;
  logic [7:0]       ctrl1;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic             wr_pend;
  logic [7:0]       wr_idx;
  logic [1:0]       ovl_sync;
  logic [1:0]       ring_sync;
  logic             ring_last;
  logic             live;
  logic             sticky;
  logic             ovl_rise;
  logic             sticky_clear;
  logic             ring_edge;
  logic             addr_ok;
  logic [7:0]       rd_byte;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_w1c;
  logic             rect_level;

  function automatic logic [7:0] word_index(input logic [31:0] a);
    word_index = a[9:2];
  endfunction : word_index

  function automatic logic wr_hit(input logic       pend,
                                  input logic [7:0] idx,
                                  input logic [7:0] target);
    wr_hit = pend && (idx == target);
  endfunction : wr_hit

  function automatic logic dct_is(input logic [7:0] c1,
                                  input logic [1:0] mode);
    dct_is = c1[BIT_DCT_HI:BIT_DCT_LO] == mode;
  endfunction : dct_is

  function automatic logic [7:0] read_mux(input logic [7:0] idx,
                                          input logic [7:0] c3,
                                          input logic [7:0] c2,
                                          input logic [7:0] c1,
                                          input logic       lv,
                                          input logic       st,
                                          input logic [1:0] is,
                                          input logic [1:0] im);
    logic [7:0] r;
    r = RESET_BYTE;
    unique case (idx)
      IDX_LINE_CTRL3: r = c3 & CTRL3_WMASK;
      IDX_OVL_STATUS: r[BIT_OVL_LIVE] = lv;
      IDX_CTRL2:
      begin
        r = c2 & CTRL2_WMASK;
        r[BIT_ROV] = st;
      end
      IDX_CTRL1: r = c1 & CTRL1_WMASK;
      IDX_IRQ_STATUS: r[IRQ_W-1:0] = is;
      IDX_IRQ_MASK: r[IRQ_W-1:0] = im;
      default: r = RESET_BYTE;
    endcase
    read_mux = r;
  endfunction : read_mux

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Two-stage synchronisers for the asynchronous pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ovl_sync  <= 2'h0;
      ring_sync <= 2'h0;
    end
    else
    begin
      ovl_sync  <= {ovl_sync[0], overload_pin};
      ring_sync <= {ring_sync[0], ring_pin};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ring_last <= 1'b0;
    else
      ring_last <= ring_sync[1];
  end

  assign ring_edge = ring_sync[1] & ~ring_last;

  // Address phase capture; only writes need a data phase slot
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= hsel & htrans[1] & hwrite;
      wr_idx  <= word_index(haddr);
    end
  end

  assign sticky_clear = wr_hit(wr_pend, wr_idx, IDX_CTRL2)
                        && !hwdata[BIT_ROV];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl3 <= RESET_BYTE;
      ctrl2 <= RESET_BYTE;
      ctrl1 <= RESET_BYTE;
    end
    else if (wr_pend)
    begin
      unique case (wr_idx)
        IDX_LINE_CTRL3: ctrl3 <= hwdata[7:0] & CTRL3_WMASK;
        IDX_CTRL2:      ctrl2 <= hwdata[7:0] & CTRL2_WMASK;
        IDX_CTRL1:      ctrl1 <= hwdata[7:0] & CTRL1_WMASK;
        default:        ctrl3 <= ctrl3;
      endcase
    end
  end

  assign irq_events = {ring_edge, ovl_rise};
  assign irq_w1c = wr_hit(wr_pend, wr_idx, IDX_IRQ_STATUS)
                   ? hwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_status <= {IRQ_W{1'b0}};
    else
      irq_status <= (irq_status & ~irq_w1c) | irq_events;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_mask <= {IRQ_W{1'b0}};
    else if (wr_hit(wr_pend, wr_idx, IDX_IRQ_MASK))
      irq_mask <= hwdata[IRQ_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  lic_ovl_track u_ovl (
    .hclk                       (hclk),
    .hresetn                    (hresetn),
    .overload_in                (ovl_sync[1]),
    .billing_tone_detect_enable (ctrl2[BIT_BTE]),
    .sticky_clear               (sticky_clear),
    .overload_live_flag         (live),
    .overload_sticky_flag       (sticky),
    .overload_rise              (ovl_rise)
  );

  // Read data registered at the address phase, valid in the data phase
  assign addr_ok = hsel & htrans[1] & ~hwrite & hready;

  always_comb
  begin
    rd_byte = read_mux(word_index(haddr), ctrl3, ctrl2, ctrl1, live,
                       sticky, irq_status, irq_mask);
  end

  // Bit seven of the status word reads zero; software must not rely on it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= RDATA_ZERO;
    else if (addr_ok)
      hrdata <= {24'h000000, rd_byte};
  end

  // Full wave passes both half cycles; half wave only the positive one
  assign rect_level = ctrl3[BIT_FULL_WAVE] ? (ring_sync[1] | ring_last)
                                           : ring_sync[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ring_detect_output <= 1'b1;
      ring_data_bit      <= 1'b0;
    end
    else
    begin
      ring_detect_output <= ~rect_level;
      ring_data_bit      <= rect_level;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      line_ctrl <= '0;
    else
    begin
      line_ctrl.tone_headroom_boost <= ctrl3[BIT_BOOST];
      line_ctrl.low_volt_termination <= ctrl3[BIT_FORCE_LV]
        && dct_is(ctrl1, DCT_STANDARD);
      line_ctrl.keep_minus1dbm_level <=
        dct_is(ctrl1, DCT_STANDARD) || dct_is(ctrl1, DCT_CURLIM);
      line_ctrl.line_voltage_adjust <=
        lic_vadj_t'(ctrl3[BIT_TRIM_HI:BIT_TRIM_LO]);
      line_ctrl.ring_full_wave_select <= ctrl3[BIT_FULL_WAVE];
      line_ctrl.ring_network_squelch  <= ctrl3[BIT_SQUELCH];
    end
  end

endmodule : lic_regs

// ===== test/lic_regs_sva.sv
// Purpose: Port assertions for the line control register bank
// Assumes: Zero wait states, one clock
// Notes:   Ring path latency is three edges
`timescale 1ns/1ps
module lic_regs_sva
  import lic_pkg::*;
(
  input wire logic           hclk,
  input wire logic           hresetn,
  input wire logic           hsel,
  input wire logic [31:0]    haddr,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic           hready,
  input wire logic [31:0]    hwdata,
  input wire logic [31:0]    hrdata,
  input wire logic           hreadyout,
  input wire logic           hresp,
  input wire logic           ring_pin,
  input wire logic           ring_detect_output,
  input wire logic           ring_data_bit,
  input wire lic_line_ctrl_t line_ctrl,
  input wire logic           irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire       acc = hsel && htrans[1] && hready;
  wire       fw  = line_ctrl.ring_full_wave_select;
  wire [4:0] wf  = {hwdata[6], hwdata[4:3], hwdata[1:0]};
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_rdata_hold: assert property (!(acc && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved without read");
  // Data phase one edge after address, controls one edge after the write
  a_ctrl_write: assert property (
    acc && hwrite && haddr == 32'h48 |-> ##3
    {line_ctrl.tone_headroom_boost, line_ctrl.line_voltage_adjust,
    fw, line_ctrl.ring_network_squelch} == $past(wf, 2))
    else $error("line controls differ from write");
  a_low_volt: assert property (line_ctrl.low_volt_termination |->
    line_ctrl.keep_minus1dbm_level)
    else $error("low volt without level keep");
  a_ring_invert: assert property (ring_detect_output != ring_data_bit)
    else $error("ring outputs not inverse");
  a_ring_half: assert property (!fw [*5] |->
    ring_data_bit == $past(ring_pin, 3))
    else $error("half wave ring wrong");
  a_ring_full: assert property (fw [*5] ##0 $past(ring_pin, 3) |->
    ring_data_bit)
    else $error("full wave ring lost");
  c_ctrl_write: cover property (acc && hwrite && haddr == 32'h48);
  c_irq: cover property ($rose(irq));
  c_ring: cover property (fw ##1 $rose(ring_data_bit));
endmodule : lic_regs_sva

bind lic_regs lic_regs_sva i_sva (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
  .ring_pin, .ring_detect_output, .ring_data_bit, .line_ctrl, .irq);

// ===== test/lic_regs_tb.sv
// Purpose: Self-checking bench for the line control register bank
// Assumes: Zero wait states, 25 MHz clock
// Notes:   Status bit seven is masked out of every overload status compare
`timescale 1ns/1ps
module lic_regs_tb
  import lic_pkg::*;
();
  logic           hclk = 0;
  logic           hresetn = 0;
  logic           hsel = 0;
  logic           hwrite = 0;
  logic           ovl = 0;
  logic           ring = 0;
  logic [1:0]     htrans = 0;
  logic [31:0]    haddr = 0;
  logic [31:0]    hwdata = 0;
  logic [31:0]    hrdata;
  logic [31:0]    rd;
  logic           hreadyout;
  logic           hresp;
  logic           rdo;
  logic           rdb;
  logic           irq;
  lic_line_ctrl_t line_ctrl;
  logic [7:0]     d;
  integer         errors = 0;
  integer         check_count = 0;
  integer         seed = 32'heb73;
  logic [7:0]     idx [7] = '{IDX_LINE_CTRL3, IDX_OVL_STATUS, IDX_CTRL2,
                              IDX_CTRL1, IDX_IRQ_STATUS, IDX_IRQ_MASK, 8'h14};

  always #20 hclk = ~hclk;

  lic_regs i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hburst(3'h0), .hprot(4'h3), .hmastlock(1'b0),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .overload_pin(ovl), .ring_pin(ring), .ring_detect_output(rdo),
    .ring_data_bit(rdb), .line_ctrl, .irq);

  function automatic logic [31:0] exp3(input logic [7:0] v);
    return {24'h0, 1'b0, v[6:3], 1'b0, v[1:0]};
  endfunction : exp3

  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, i, 2'h0};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (60000) @(posedge hclk);
    errors++;
    stop_test();
  end

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (idx[k])
    begin
      bus(0, idx[k], 0);
      chk("reset", 0, k == 1 ? rd & 32'hffff_ff7f : rd);
    end
    for (int k = 0; k < 10; k++)
    begin
      d = k == 0 ? 8'hff : 8'($random(seed));
      d[4:3] = k[1:0];
      bus(1, IDX_LINE_CTRL3, {24'h0, d});
      bus(0, IDX_LINE_CTRL3, 0);
      chk("ctrl3", exp3(d), rd);
      chk("lctrl", {d[6], d[4:3], d[1:0]},
          {line_ctrl.tone_headroom_boost, line_ctrl.line_voltage_adjust,
           line_ctrl.ring_full_wave_select, line_ctrl.ring_network_squelch});
    end
    for (int k = 1; k < 4; k++)
    begin
      bus(1, IDX_CTRL1, k << 2);
      bus(1, IDX_LINE_CTRL3, 32'h20);
      bus(0, IDX_CTRL1, 0);
      chk("dct", k << 2, rd);
      chk("lowv", k == 2, line_ctrl.low_volt_termination);
      chk("keep", k >= 2, line_ctrl.keep_minus1dbm_level);
    end
    bus(1, IDX_IRQ_MASK, 3);
    ovl <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(0, IDX_OVL_STATUS, 0);
    chk("ovl off", 0, rd & 32'hffff_ff7f);
    bus(0, IDX_CTRL2, 0);
    chk("rov off", 0, rd);
    bus(1, IDX_CTRL2, 4);
    repeat (4) @(posedge hclk);
    bus(0, IDX_OVL_STATUS, 0);
    chk("ovl on", 4, rd & 32'hffff_ff7f);
    ovl <= 1'b0;
    repeat (4) @(posedge hclk);
    bus(0, IDX_OVL_STATUS, 0);
    chk("ovl gone", 0, rd & 32'hffff_ff7f);
    bus(0, IDX_CTRL2, 0);
    chk("rov kept", 6, rd);
    chk("irq on", 1, irq);
    bus(1, IDX_CTRL2, 4);
    bus(0, IDX_CTRL2, 0);
    chk("rov clr", 4, rd);
    bus(1, IDX_IRQ_MASK, 0);
    bus(0, IDX_IRQ_STATUS, 0);
    chk("irq stat", 1, rd);
    chk("irq mask", 0, irq);
    bus(1, IDX_IRQ_STATUS, 1);
    bus(1, IDX_IRQ_MASK, 3);
    bus(0, IDX_IRQ_STATUS, 0);
    chk("irq clr", 0, rd);
    chk("irq off", 0, irq);
    for (int k = 0; k < 2; k++)
    begin
      bus(1, IDX_LINE_CTRL3, k << 1);
      repeat (6) @(posedge hclk);
      ring <= 1'b1;
      repeat (4) @(posedge hclk);
      chk("ring", 1, rdb);
      chk("ring pin", 0, rdo);
      ring <= 1'b0;
      // Full wave keeps the output one sample longer than half wave
      repeat (4) @(posedge hclk);
      chk("ring tail", k, rdb);
      chk("ring pin tail", k == 0, rdo);
      repeat (2) @(posedge hclk);
    end
    bus(0, IDX_IRQ_STATUS, 0);
    chk("ring irq", 2, rd);
    chk("ring irq out", 1, irq);
    // Squelch held one millisecond before release
    bus(1, IDX_LINE_CTRL3, 1);
    repeat (25000) @(posedge hclk);
    bus(1, IDX_LINE_CTRL3, 0);
    stop_test();
  end
endmodule : lic_regs_tb
